// ---- common/rxfcal_pkg.sv ----
// Package: register map, field layouts, reset values and shared types
package rxfcal_pkg;
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_RSVD_A = 8'h69;
  localparam logic [7:0] OFS_ASSESS_BW = 8'h6A;
  localparam logic [7:0] OFS_BW_SCALE = 8'h6B;
  localparam logic [7:0] OFS_OFFSET_TC = 8'h6C;
  localparam logic [7:0] OFS_ASSESS_GAIN = 8'h6D;
  localparam logic [7:0] OFS_TUNE_VALUE = 8'h6E;
  localparam logic [7:0] OFS_TUNE_TRIG = 8'h6F;
  localparam logic [7:0] OFS_SLOW_TRIM = 8'h70;
  // Field positions
  localparam int POS_DOUBLE_BW = 7;
  localparam int POS_TUNE_FORCE = 7;
  localparam int POS_WAKE_EN = 4;
  localparam int POS_GO = 0;
  localparam int POS_DIV_LO = 4;
  // Reset values
  localparam logic [7:0] RST_RSVD_A = 8'h00;
  localparam logic [6:0] RST_BW_DIVISOR = 7'h01;
  localparam logic [2:0] RST_BW_SCALE = 3'h0;
  localparam logic [2:0] RST_OFFSET_TC = 3'h3;
  localparam logic [4:0] RST_GAIN = 5'h18;
  localparam logic [6:0] RST_TUNE = 7'h00;
  localparam logic [6:0] TUNE_MIDSCALE = 7'h40;
  localparam logic [3:0] RST_DIV = 4'h0;
  // Gain exponent offset and bandwidth denominator factor
  localparam logic [5:0] GAIN_EXP_BIAS = 6'h15;
  localparam logic [7:0] BW_DENOM_FACTOR = 8'hB4;
  // Engine step counts: tune in core_clk cycles, slow cal in divided ticks
  localparam logic [7:0] TUNE_STEPS = 8'h07;
  localparam logic [7:0] SLOW_CAL_CYCLES = 8'h20;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxfcal_req_t;

  // Settings steering the receive path
  typedef struct packed {
    logic double_bw;
    logic [6:0] bw_divisor;
    logic [2:0] scale_code;
    logic [2:0] offset_tc_code;
    logic [4:0] gain_code;
    logic signed [5:0] gain_shift;
  } rxfcal_rx_t;

  // Tune engine states, Gray along idle->run->done
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_RUN = 2'b01,
    TS_DONE = 2'b11
  } rxfcal_tstate_t;
endpackage

// ---- core/rxfcal_slow_cal.sv ----
`timescale 1ns/1ps
// Low speed clock calibration sequencer with its divider
module rxfcal_slow_cal (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [3:0] div_code,
  // Status
  output logic busy,
  output logic done_pulse
);
  import rxfcal_pkg::*;

  logic [3:0] pre_r; // Prescaler count
  logic [7:0] cnt_r; // Divided ticks remaining
  logic tick;

  // Codes 0 and 1 both mean no division
  assign tick = (div_code <= 4'h1) ? 1'b1 : (pre_r >= div_code - 4'h1);

  // Prescaler, only runs while busy
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 4'h0;
    end else if (ce) begin
      if (!busy || tick) begin
        pre_r <= 4'h0;
      end else begin
        pre_r <= pre_r + 4'h1;
      end
    end
  end

  // Calibration window count and completion pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      busy <= 1'b0;
      done_pulse <= 1'b0;
    end else if (ce) begin
      done_pulse <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          cnt_r <= SLOW_CAL_CYCLES;
        end
      end else if (tick) begin
        if (cnt_r == 8'h01) begin
          busy <= 1'b0;
          done_pulse <= 1'b1;
        end
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// ---- core/rxfcal_regs.sv ----
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Receive filter and calibration register bank
// Notes on behaviour
// - Wide bit doubles assessment bandwidth
// - Bandwidth = clk*(wide+1)/(divisor*180)
// - Scale code scales both filter bandwidths
// - Offset time constant code, automatic mode
// - Assessment gain is 2^-(code-21)
// - Force bit selects forced tune value
// - Auto reads live value; forced applies written
// - Clock stable loads tune midscale when tune engine idle
// - Wake enable runs tune after sleep
// - Tune go self-clears on completion
// - Slow go self-clears on completion
// - Divider codes 0,1 mean no division
// - Reserved register reads zero, read-only
module rxfcal_regs (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire rxfcal_pkg::rxfcal_req_t req,
  output logic [7:0] rdata,
  // Device events (asynchronous pins)
  input wire logic clk_stable,
  input wire logic sleep_exit,
  // Tune engine result from analogue search
  input wire logic [6:0] tune_search,
  // Outputs to the receive path
  output rxfcal_pkg::rxfcal_rx_t rx_cfg,
  output logic [6:0] tune_apply,
  output logic tune_busy,
  output logic slow_cal_busy,
  output logic slow_cal_done
);
  import rxfcal_pkg::*;

  // Software fields
  logic double_bw_r; // Wideband bit
  logic [6:0] bw_div_r; // Assessment divisor
  logic [2:0] scale_r; // Bandwidth scale code
  logic [2:0] offset_tc_r; // Offset filter code
  logic [4:0] gain_r; // Assessment gain code
  logic force_r; // Forced tune mode
  logic [6:0] tune_wr_r; // Value written by software
  logic [6:0] tune_live_r; // Value in use in auto mode
  logic wake_en_r; // Tune on wake enable
  logic tune_go_r; // Tune start/busy flag
  logic slow_go_r; // Slow cal start/busy flag
  logic [3:0] div_r; // Slow cal divider code
  rxfcal_tstate_t tstate_r; // Tune engine state
  logic [7:0] tstep_r; // Tune step count
  // Pin synchronisers, three stages each
  logic [2:0] stab_sy_r;
  logic [2:0] wake_sy_r;
  logic stab_q_r; // Filtered clock-stable level
  logic wake_q_r; // Filtered sleep-exit level
  logic stab_rise;
  logic wake_rise;
  logic wr_hit_trig;
  logic slow_start;
  logic slow_busy;
  logic slow_done;

  // Gain shift arithmetic: code minus bias
  function automatic logic signed [5:0] gain_exp(input logic [4:0] c);
    gain_exp = $signed({1'b0, c}) - $signed(GAIN_EXP_BIAS);
  endfunction

  // Write decode helper
  function automatic logic hit(input rxfcal_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // Synchronisers; first stage only feeds the second
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stab_sy_r <= 3'h0;
      wake_sy_r <= 3'h0;
    end else if (ce) begin
      stab_sy_r <= {stab_sy_r[1:0], clk_stable};
      wake_sy_r <= {wake_sy_r[1:0], sleep_exit};
    end
  end

  // Accept a level change only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stab_q_r <= 1'b0;
      wake_q_r <= 1'b0;
    end else if (ce) begin
      if (stab_sy_r[1] == stab_sy_r[2]) begin
        stab_q_r <= stab_sy_r[2];
      end
      if (wake_sy_r[1] == wake_sy_r[2]) begin
        wake_q_r <= wake_sy_r[2];
      end
    end
  end

  assign stab_rise = (stab_sy_r[1] == stab_sy_r[2]) && stab_sy_r[2]
    && !stab_q_r;
  assign wake_rise = (wake_sy_r[1] == wake_sy_r[2]) && wake_sy_r[2]
    && !wake_q_r;
  assign wr_hit_trig = hit(req, OFS_TUNE_TRIG);

  // Receive path settings, writable fields only; reserved bits dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      double_bw_r <= 1'b0;
      bw_div_r <= RST_BW_DIVISOR;
      scale_r <= RST_BW_SCALE;
      offset_tc_r <= RST_OFFSET_TC;
      gain_r <= RST_GAIN;
    end else if (ce) begin
      if (hit(req, OFS_ASSESS_BW)) begin
        double_bw_r <= req.wdata[POS_DOUBLE_BW];
        bw_div_r <= req.wdata[6:0];
      end
      if (hit(req, OFS_BW_SCALE)) begin
        scale_r <= req.wdata[2:0];
      end
      if (hit(req, OFS_OFFSET_TC)) begin
        offset_tc_r <= req.wdata[2:0];
      end
      if (hit(req, OFS_ASSESS_GAIN)) begin
        gain_r <= req.wdata[4:0];
      end
    end
  end

  // Tune mode and written value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      force_r <= 1'b0;
      tune_wr_r <= RST_TUNE;
      wake_en_r <= 1'b0;
    end else if (ce) begin
      if (hit(req, OFS_TUNE_VALUE)) begin
        force_r <= req.wdata[POS_TUNE_FORCE];
        tune_wr_r <= req.wdata[6:0];
      end
      if (wr_hit_trig) begin
        wake_en_r <= req.wdata[POS_WAKE_EN];
      end
    end
  end

  // Tune go flag: set by software or wake, cleared at done; set wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tune_go_r <= 1'b0;
    end else if (ce) begin
      if ((wr_hit_trig && req.wdata[POS_GO]) ||
          (wake_rise && wake_en_r)) begin
        tune_go_r <= 1'b1;
      end else if (tstate_r == TS_DONE) begin
        tune_go_r <= 1'b0;
      end
    end
  end

  // Tune engine: searches for a fixed step count, then latches result in auto mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tstate_r <= TS_IDLE;
      tstep_r <= 8'h00;
      tune_live_r <= RST_TUNE;
    end else if (ce) begin
      unique case (tstate_r)
        TS_IDLE: begin
          if (stab_rise) begin
            tune_live_r <= TUNE_MIDSCALE;
          end
          if (tune_go_r) begin
            tstate_r <= TS_RUN;
            tstep_r <= TUNE_STEPS;
          end
        end
        TS_RUN: begin
          tstep_r <= tstep_r - 8'h01;
          if (tstep_r == 8'h01) begin
            tstate_r <= TS_DONE;
            if (!force_r) begin
              tune_live_r <= tune_search;
            end
          end
        end
        TS_DONE: begin
          tstate_r <= TS_IDLE;
        end
        default: begin
          tstate_r <= TS_IDLE;
        end
      endcase
    end
  end

  // Slow clock calibration flag; engine clears it on completion
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_go_r <= 1'b0;
      div_r <= RST_DIV;
    end else if (ce) begin
      if (hit(req, OFS_SLOW_TRIM)) begin
        div_r <= req.wdata[7:POS_DIV_LO];
      end
      if (hit(req, OFS_SLOW_TRIM) && req.wdata[POS_GO]) begin
        slow_go_r <= 1'b1;
      end else if (slow_done) begin
        slow_go_r <= 1'b0;
      end
    end
  end

  assign slow_start = slow_go_r && !slow_busy && !slow_done;

  // Slow clock sequencer
  rxfcal_slow_cal u_slow (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(slow_start),
    .div_code(div_r),
    .busy(slow_busy),
    .done_pulse(slow_done)
  );

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (req.rd) begin
        unique case (req.addr)
          OFS_RSVD_A: rdata <= RST_RSVD_A;
          OFS_ASSESS_BW: rdata <= {double_bw_r, bw_div_r};
          OFS_BW_SCALE: rdata <= {5'h00, scale_r};
          OFS_OFFSET_TC: rdata <= {5'h00, offset_tc_r};
          OFS_ASSESS_GAIN: rdata <= {3'h0, gain_r};
          OFS_TUNE_VALUE: rdata <= {force_r,
            force_r ? tune_wr_r : tune_live_r};
          OFS_TUNE_TRIG: rdata <= {3'h0, wake_en_r, 3'h0, tune_go_r};
          OFS_SLOW_TRIM: rdata <= {div_r, 3'h0, slow_go_r};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  // Registered outputs to the receive path
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cfg <= '0;
      tune_apply <= RST_TUNE;
      tune_busy <= 1'b0;
      slow_cal_busy <= 1'b0;
      slow_cal_done <= 1'b0;
    end else if (ce) begin
      rx_cfg.double_bw <= double_bw_r;
      rx_cfg.bw_divisor <= bw_div_r;
      rx_cfg.scale_code <= scale_r;
      rx_cfg.offset_tc_code <= offset_tc_r;
      rx_cfg.gain_code <= gain_r;
      rx_cfg.gain_shift <= gain_exp(gain_r);
      tune_apply <= force_r ? tune_wr_r : tune_live_r;
      tune_busy <= tune_go_r;
      slow_cal_busy <= slow_go_r;
      slow_cal_done <= slow_done;
    end
  end

  // Checks on the tune and slow calibration control, reserved read bits and gain shift
  a_tune_go_clears: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && tstate_r == TS_DONE && !wr_hit_trig
    && !wake_rise |=> !tune_go_r)
    else $error("tune go not cleared at done");
  a_forced_apply: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && force_r
    |=> !ce || tune_apply == $past(tune_wr_r))
    else $error("forced value not applied");
  a_mode_select: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && !force_r
    |=> !ce || tune_apply == $past(tune_live_r))
    else $error("auto value not applied");
  a_wake_tune: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && wake_rise && wake_en_r
    |=> tune_go_r || !ce)
    else $error("wake did not start tune");
  a_no_wake_tune: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && !tune_go_r && !wr_hit_trig
    && !(wake_rise && wake_en_r) |=> !tune_go_r || !ce)
    else $error("tune started unasked");
  a_midscale_load: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && stab_rise && tstate_r == TS_IDLE
    |=> tune_live_r == TUNE_MIDSCALE)
    else $error("midscale not loaded");
  a_rsvd_reads: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && req.rd && req.addr == OFS_RSVD_A
    |=> !ce || rdata == 8'h00)
    else $error("reserved register not zero");
  a_gain_shift: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce |=> !ce
    || rx_cfg.gain_shift == $signed({1'b0, $past(gain_r)}) - 6'sh15)
    else $error("gain shift wrong");
  a_slow_clear: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && slow_done && !hit(req, OFS_SLOW_TRIM)
    |=> !slow_go_r)
    else $error("slow go not cleared");
  a_scale_rsvd: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && req.rd && req.addr == OFS_BW_SCALE
    |=> !ce || rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");
  // Receive path copies follow the fields; a frozen enable holds them
  a_wide_follow: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce |=> !ce
    || rx_cfg.double_bw == $past(double_bw_r))
    else $error("wide bit not passed on");
  a_divisor_follow: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce |=> !ce
    || rx_cfg.bw_divisor == $past(bw_div_r))
    else $error("divisor not passed on");
  a_scale_follow: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce |=> !ce
    || rx_cfg.scale_code == $past(scale_r))
    else $error("scale code not passed on");
  a_offset_follow: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce |=> !ce
    || rx_cfg.offset_tc_code == $past(offset_tc_r))
    else $error("offset code not passed on");
  a_auto_readback: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && req.rd && req.addr == OFS_TUNE_VALUE
    && !force_r |=> !ce || rdata == {1'b0, $past(tune_live_r)})
    else $error("auto readback not live value");
  a_tc_rsvd: assert property (@(posedge core_clk)
    disable iff (!rst_b) ce && req.rd && req.addr == OFS_OFFSET_TC
    |=> !ce || rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");
  a_ce_freeze: assert property (@(posedge core_clk)
    disable iff (!rst_b) !ce
    |=> $stable(tune_apply) && $stable(rdata))
    else $error("state moved while enable low");
endmodule

// ---- sim/rxfcal_regs_bench.sv ----
// Self-checking bench for the receive filter and calibration registers
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  errors++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module rxfcal_regs_bench;
  import rxfcal_pkg::*;
  // Stimulus, all given a value at time zero
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  rxfcal_req_t req = '0;
  logic clk_stable = 1'b0;
  logic sleep_exit = 1'b0;
  logic [6:0] tune_search = 7'h00;
  // Observed outputs
  logic [7:0] rdata;
  rxfcal_rx_t rx_cfg;
  logic [6:0] tune_apply;
  logic tune_busy;
  logic slow_cal_busy;
  logic slow_cal_done;
  // Counters, read notes and random state
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hBB01;
  string nq[$];
  logic [7:0] eq[$];
  logic pend = 1'b0;
  string mn;
  logic [7:0] me;

  // Clock enable driven by the bench; one scenario freezes it
  rxfcal_regs dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
    .req(req), .rdata(rdata), .clk_stable(clk_stable),
    .sleep_exit(sleep_exit), .tune_search(tune_search), .rx_cfg(rx_cfg),
    .tune_apply(tune_apply), .tune_busy(tune_busy),
    .slow_cal_busy(slow_cal_busy), .slow_cal_done(slow_cal_done));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Xorshift source, low byte used as stimulus
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One bus cycle; strobes are never lowered inside, so no double drive
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // Read notes its expectation before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    nq.push_back(n);
    eq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded wait on the tune engine's busy level
  task automatic wait_tune(input logic lvl);
    for (int i = 0; i < 60 && tune_busy !== lvl; i++) @(posedge core_clk);
  endtask

  // Watcher: read data stands one cycle after the strobe, else zero
  always @(posedge core_clk) begin
    if (pend && eq.size() > 0) begin
      mn = nq.pop_front();
      me = eq.pop_front();
      `CHK(mn, me, rdata)
    end else if (rst_b) begin
      `CHK("rdata idle", 8'h00, rdata)
    end
    pend <= req.rd;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR timeout expected 0 seen %0d", cyc);
      results();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] rv[8];
    logic [7:0] v;
    logic [7:0] g;
    int dur[4];
    rv = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h18, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset values of the whole range
    for (int i = 0; i < 8; i++)
      rd(OFS_RSVD_A + 8'(i), rv[i], "reset");
    rd(8'h71, 8'h00, "unmapped");
    idle(1);
    `CHK("reset shift", 6'h03, rx_cfg.gain_shift)
    // Reserved bits ignore writes
    wr(OFS_RSVD_A, 8'hFF);
    wr(OFS_BW_SCALE, 8'hF8);
    wr(OFS_OFFSET_TC, 8'hF8);
    wr(OFS_ASSESS_GAIN, 8'hE0);
    wr(OFS_TUNE_TRIG, 8'hEE);
    wr(OFS_SLOW_TRIM, 8'h0E);
    for (int i = 0; i < 8; i++)
      if (i != 1 && i != 5) rd(OFS_RSVD_A + 8'(i), 8'h00, "rsvd");
    // Divisor boundaries and a random one, never zero
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h81 : (i == 1) ? 8'h7F : xs();
      if (v[6:0] == 7'h00) v[0] = 1'b1;
      wr(OFS_ASSESS_BW, v);
      rd(OFS_ASSESS_BW, v, "bw reg");
      idle(1);
      `CHK("double bw", v[7], rx_cfg.double_bw)
      `CHK("divisor", v[6:0], rx_cfg.bw_divisor)
    end
    // Scale codes 0 to 5, time constant codes 0 to 4, random gain
    for (int c = 0; c < 6; c++) begin
      g = xs();
      wr(OFS_BW_SCALE, {g[7:3], 3'(c)});
      wr(OFS_OFFSET_TC, {g[7:3], 3'(c % 5)});
      wr(OFS_ASSESS_GAIN, g);
      rd(OFS_BW_SCALE, {5'h00, 3'(c)}, "scale reg");
      rd(OFS_OFFSET_TC, {5'h00, 3'(c % 5)}, "tc reg");
      rd(OFS_ASSESS_GAIN, {3'h0, g[4:0]}, "gain reg");
      idle(1);
      `CHK("scale", 3'(c), rx_cfg.scale_code)
      `CHK("tc", 3'(c % 5), rx_cfg.offset_tc_code)
      `CHK("shift", 6'({1'b0, g[4:0]}) - 6'h15, rx_cfg.gain_shift)
      `CHK("gain code", g[4:0], rx_cfg.gain_code)
    end
    // Clock stable loads midscale; auto mode ignores writes
    clk_stable <= 1'b1;
    idle(8);
    rd(OFS_TUNE_VALUE, 8'h40, "midscale");
    wr(OFS_TUNE_VALUE, 8'h25);
    rd(OFS_TUNE_VALUE, 8'h40, "auto write");
    v = xs() | 8'h80;
    wr(OFS_TUNE_VALUE, v);
    rd(OFS_TUNE_VALUE, v, "forced reg");
    idle(1);
    `CHK("forced apply", v[6:0], tune_apply)
    wr(OFS_TUNE_VALUE, 8'h00);
    idle(2);
    `CHK("auto apply", 7'h40, tune_apply)
    // Software tune run, go clears itself
    v = xs();
    tune_search <= v[6:0];
    wr(OFS_TUNE_TRIG, 8'h01);
    idle(1);
    `CHK("tune busy", 1'b1, tune_busy)
    wait_tune(1'b0);
    rd(OFS_TUNE_TRIG, 8'h00, "tune go");
    rd(OFS_TUNE_VALUE, {1'b0, v[6:0]}, "tune result");
    // Wake tune enabled, then disabled
    wr(OFS_TUNE_TRIG, 8'h10);
    idle(0);
    sleep_exit <= 1'b1;
    wait_tune(1'b1);
    `CHK("wake tune", 1'b1, tune_busy)
    sleep_exit <= 1'b0;
    wait_tune(1'b0);
    rd(OFS_TUNE_TRIG, 8'h10, "wake en");
    wr(OFS_TUNE_TRIG, 8'h00);
    idle(0);
    sleep_exit <= 1'b1;
    wait_tune(1'b1);
    `CHK("no wake tune", 1'b0, tune_busy)
    sleep_exit <= 1'b0;
    // Slow calibration with divider codes 0 to 3
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SLOW_TRIM, {4'(c), 4'h1});
      idle(1);
      `CHK("slow busy", 1'b1, slow_cal_busy)
      dur[c] = 0;
      while (slow_cal_done !== 1'b1 && dur[c] < 3000) begin
        @(posedge core_clk);
        dur[c]++;
      end
      `CHK("slow done", 1'b1, slow_cal_done)
      idle(2);
      `CHK("slow idle", 1'b0, slow_cal_busy)
      rd(OFS_SLOW_TRIM, {4'(c), 4'h0}, "slow go");
    end
    // Enable low freezes everything, so this write is lost
    idle(1);
    ce <= 1'b0;
    wr(OFS_BW_SCALE, 8'h02);
    idle(1);
    ce <= 1'b1;
    rd(OFS_BW_SCALE, 8'h05, "frozen write");
    idle(1);
    `CHK("undivided", dur[0], dur[1])
    `CHK("divided", 1'b1, dur[3] > 2 * dur[0])
    results();
  end
endmodule
